// ### src/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  localparam logic [2:0] ADDR_CTRL_ZERO   = 3'h0;
  localparam logic [2:0] ADDR_CTRL_ONE    = 3'h1;
  localparam logic [2:0] ADDR_RESULT_HIGH = 3'h2;
  localparam logic [2:0] ADDR_RESULT_LOW  = 3'h3;
  localparam logic [2:0] ADDR_STATUS      = 3'h4;
  localparam logic [7:0] CTRL_ZERO_RESET  = 8'h00;
  localparam logic [7:0] CTRL_ONE_RESET   = 8'h00;
  localparam int BIT_START    = 7;
  localparam int BIT_BUSY     = 6;
  localparam int BIT_POWER    = 5;
  localparam int BIT_JUSTIFY  = 4;
  localparam int POS_INSRC    = 5;
  localparam int POS_REFSRC   = 3;
  localparam int POS_CLKDIV   = 0;
  localparam int SAMPLE_TICKS  = 4;
  localparam int CONVERT_TICKS = 12;
  localparam int TOTAL_TICKS   = SAMPLE_TICKS + CONVERT_TICKS;
  localparam logic [1:0] REF_INTERNAL_SUPPLY = 2'h1;
  localparam logic [2:0] SRC_BANDGAP = 3'h1;
  localparam logic [2:0] SRC_AMP_ZERO = 3'h2;
  localparam logic [2:0] SRC_AMP_ONE = 3'h3;
  localparam logic [2:0] SRC_LINE_AMP = 3'h4;
  typedef enum logic [2:0] {
    ROUTE_EXTERNAL, ROUTE_BANDGAP, ROUTE_AMP_ZERO, ROUTE_AMP_ONE, ROUTE_LINE_AMP
  } route_t;
  typedef enum logic [1:0] {S_IDLE, S_ARMED, S_SAMPLE, S_CONVERT} conv_state_t;
endpackage

// ### src/conv_clock_if.sv
`timescale 1ns/1ps
`default_nettype none
interface conv_clock_if;
  logic [2:0] divider_select;
  logic       run;
  logic       tick;
  modport source (input divider_select, input run, output tick);
  modport sink   (output divider_select, output run, input tick);
endinterface
`default_nettype wire

// ### src/conv_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
module conv_clock_divider (
  input  wire logic         i_clock,
  input  wire logic         i_rst_n,
  conv_clock_if.source      clk_if
);
  logic [6:0] count_reg;
  logic [6:0] terminal;

  always_comb begin
    terminal = 7'((8'h01 << clk_if.divider_select) - 8'h01);
  end

  // one-cycle tick every 2**code system clocks; code 0 ticks every cycle
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg   <= 7'h00;
      clk_if.tick <= 1'b0;
    end else if (!clk_if.run) begin
      count_reg   <= 7'h00;
      clk_if.tick <= 1'b0;
    end else if (count_reg >= terminal) begin
      count_reg   <= 7'h00;
      clk_if.tick <= 1'b1; // R3
    end else begin
      count_reg   <= count_reg + 7'h01;
      clk_if.tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### src/adc_control_sequencer.sv
// Functional notes
// (R1) input source code picks external or internal signal
// (R2) reference code 01 picks supply, else pin
// (R3) clock divider code gives divide by 2**code
// (R4) start bit low-high-low starts one conversion
// (R5) busy flag rises when conversion starts
// (R6) busy flag falls when conversion ends
// (R7) completion sets request flag, interrupt when enabled
// (R8) software may poll busy instead of interrupt
// (R9) software keeps converter clock 0.5 to 10 us
// (R10) software waits settling after power enable
// (R11) software clears power enable when idle
// (R12) internal source needs nonexistent external channel
// (R13) supply reference forbids reference pin function
// (R14) pin reference needs other pin functions off
// (R15) conversion is 4 sample plus 12 convert ticks
// (R16) justify bit selects left or right result
// (R17) channel codes 0-3,7 select pins, 8-15 float
// (R18) results hold while converter disabled
// (R19) start taken on falling edge, sample next tick
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module adc_control_sequencer
  import adc_ctrl_pkg::*;
(
  input  wire logic                   i_clock,
  input  wire logic                   i_resetn,
  input  wire logic [2:0]             i_addr,
  input  wire logic [7:0]             i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [7:0]             o_rdata,
  input  wire logic                   i_irq_enable,
  input  wire logic [11:0]            i_conv_result,
  output logic                        o_power_enable,
  output logic                        o_sample,
  output logic                        o_convert,
  output logic                        o_conv_clock_tick,
  output logic                        o_ext_pin_enable,
  output logic      [2:0]             o_ext_pin_index,
  output adc_ctrl_pkg::route_t        o_route,
  output logic                        o_ref_internal,
  output logic                        o_irq_request,
  output logic                        o_irq_pulse
);
  import adc_ctrl_pkg::*;

  logic [1:0]  rst_sync_reg;
  logic        rst_n;
  logic [7:0]  ctrl_zero_reg;
  logic [7:0]  ctrl_one_reg;
  logic        busy_reg;
  logic [11:0] result_reg;
  logic        start_armed_reg;
  logic        start_pending_reg;
  logic [4:0]  tick_count_reg;
  conv_state_t state_reg;
  logic        done;
  logic        irq_flag_reg;
  logic [7:0]  result_high;
  logic [7:0]  result_low;
  logic        justify;
  logic        start_bit_next;
  logic        start_fall;

  conv_clock_if clk_if ();

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign clk_if.divider_select = ctrl_one_reg[POS_CLKDIV +: 3];
  assign clk_if.run            = ctrl_zero_reg[BIT_POWER];

  conv_clock_divider u_divider (
    .i_clock (i_clock),
    .i_rst_n (rst_n),
    .clk_if  (clk_if.source)
  );

  assign justify        = ctrl_zero_reg[BIT_JUSTIFY];
  assign start_bit_next = (i_wr && i_addr == ADDR_CTRL_ZERO) ? i_wdata[BIT_START] : ctrl_zero_reg[BIT_START];
  // falling edge of the stored start bit, taken from the write itself
  assign start_fall     = ctrl_zero_reg[BIT_START] && !start_bit_next;
  assign done           = (state_reg == S_CONVERT) && clk_if.tick && (tick_count_reg == 5'(TOTAL_TICKS - 1));

  // control registers; busy bit is read-only and not stored here
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_zero_reg <= CTRL_ZERO_RESET;
      ctrl_one_reg  <= CTRL_ONE_RESET;
    end else if (i_wr) begin
      if (i_addr == ADDR_CTRL_ZERO) begin
        ctrl_zero_reg <= i_wdata & ~(8'h01 << BIT_BUSY);
      end
      if (i_addr == ADDR_CTRL_ONE) begin
        ctrl_one_reg <= i_wdata;
      end
    end
  end

  // start detection: a rise arms, the following fall requests
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      start_armed_reg   <= 1'b0;
      start_pending_reg <= 1'b0;
    end else begin
      if (!ctrl_zero_reg[BIT_START] && start_bit_next) begin
        start_armed_reg <= 1'b1;
      end else if (start_fall) begin
        start_armed_reg <= 1'b0;
      end
      if (start_fall && start_armed_reg && ctrl_zero_reg[BIT_POWER]) begin
        start_pending_reg <= 1'b1; // R4 R19
      end else if (state_reg != S_IDLE || !ctrl_zero_reg[BIT_POWER]) begin
        start_pending_reg <= 1'b0;
      end
    end
  end

  // sequencer; a restart during a conversion is ignored, except one whose fall comes in the completion cycle
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= S_IDLE;
      tick_count_reg <= 5'h00;
      busy_reg       <= 1'b0;
    end else if (!ctrl_zero_reg[BIT_POWER]) begin
      // powering down aborts without touching the result
      state_reg      <= S_IDLE;
      tick_count_reg <= 5'h00;
      busy_reg       <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (start_pending_reg) begin
            state_reg <= S_ARMED;
            busy_reg  <= 1'b1; // R5
          end
        end
        S_ARMED: begin
          if (clk_if.tick) begin
            state_reg      <= S_SAMPLE; // R19
            tick_count_reg <= 5'h00;
          end
        end
        S_SAMPLE: begin
          if (clk_if.tick) begin
            tick_count_reg <= tick_count_reg + 5'h01;
            if (tick_count_reg == 5'(SAMPLE_TICKS - 1)) begin
              state_reg <= S_CONVERT; // R15
            end
          end
        end
        S_CONVERT: begin
          if (clk_if.tick) begin
            tick_count_reg <= tick_count_reg + 5'h01;
          end
          if (done) begin
            state_reg <= S_IDLE; // R15
            busy_reg  <= 1'b0; // R6
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // result capture only happens on completion, so power-down keeps it
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= 12'h000;
    end else if (done && ctrl_zero_reg[BIT_POWER]) begin
      result_reg <= i_conv_result; // R18
    end
  end

  // request flag is cleared by reading the status register; set wins
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_flag_reg <= 1'b0;
      o_irq_pulse  <= 1'b0;
    end else begin
      if (done) begin
        irq_flag_reg <= 1'b1; // R7
      end else if (i_rd && i_addr == ADDR_STATUS) begin
        irq_flag_reg <= 1'b0;
      end
      o_irq_pulse <= done && i_irq_enable; // R7
    end
  end

  always_comb begin
    if (justify) begin
      result_high = {4'h0, result_reg[11:8]}; // R16
      result_low  = result_reg[7:0];
    end else begin
      result_high = result_reg[11:4];
      result_low  = {result_reg[3:0], 4'h0}; // R16
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_CTRL_ZERO:   o_rdata <= ctrl_zero_reg | {1'b0, busy_reg, 6'h00};
        ADDR_CTRL_ONE:    o_rdata <= ctrl_one_reg;
        ADDR_RESULT_HIGH: o_rdata <= result_high;
        ADDR_RESULT_LOW:  o_rdata <= result_low;
        ADDR_STATUS:      o_rdata <= {7'h00, irq_flag_reg};
        default:          o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // analog-side controls
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_power_enable    <= 1'b0;
      o_sample          <= 1'b0;
      o_convert         <= 1'b0;
      o_conv_clock_tick <= 1'b0;
      o_ext_pin_enable  <= 1'b0;
      o_ext_pin_index   <= 3'h0;
      o_route           <= ROUTE_EXTERNAL;
      o_ref_internal    <= 1'b0;
      o_irq_request     <= 1'b0;
    end else begin
      o_power_enable    <= ctrl_zero_reg[BIT_POWER];
      o_sample          <= (state_reg == S_SAMPLE);
      o_convert         <= (state_reg == S_CONVERT);
      o_conv_clock_tick <= clk_if.tick;
      // reserved codes 4-6 and 8-15 connect no pin
      o_ext_pin_enable  <= !ctrl_zero_reg[3] &&
                           (ctrl_zero_reg[2] == 1'b0 || ctrl_zero_reg[1:0] == 2'h3); // R17
      o_ext_pin_index   <= ctrl_zero_reg[2:0]; // R17
      case (ctrl_one_reg[POS_INSRC +: 3])
        SRC_BANDGAP:  o_route <= ROUTE_BANDGAP; // R1
        SRC_AMP_ZERO: o_route <= ROUTE_AMP_ZERO; // R1
        SRC_AMP_ONE:  o_route <= ROUTE_AMP_ONE; // R1
        SRC_LINE_AMP: o_route <= ROUTE_LINE_AMP; // R1
        default:      o_route <= ROUTE_EXTERNAL; // R1
      endcase
      o_ref_internal    <= (ctrl_one_reg[POS_REFSRC +: 2] == REF_INTERNAL_SUPPLY); // R2
      o_irq_request     <= irq_flag_reg;
    end
  end
endmodule
`default_nettype wire

// ### testbench/adc_control_sequencer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module adc_control_sequencer_monitor
  import adc_ctrl_pkg::*;
(
  input wire logic       i_clock,
  input wire logic       i_resetn,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_irq_enable,
  input wire logic       o_power_enable,
  input wire logic       o_sample,
  input wire logic       o_convert,
  input wire logic       o_ext_pin_enable,
  input wire route_t     o_route,
  input wire logic       o_ref_internal,
  input wire logic       o_irq_request,
  input wire logic       o_irq_pulse
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  sequence ctrl1_write;
    i_wr && i_addr == ADDR_CTRL_ONE;
  endsequence
  sequence conv_end;
    $fell(o_convert) ##0 o_power_enable;
  endsequence
  chk_ref_internal: assert property (ctrl1_write ##0 i_wdata[4:3] == 2'h1 |-> ##2 o_ref_internal)
    else $error("reference select not internal");
  chk_route_bandgap: assert property (ctrl1_write ##0 i_wdata[7:5] == 3'h1 |-> ##2 o_route == ROUTE_BANDGAP)
    else $error("bandgap route missing");
  chk_pin_float: assert property (i_wr && i_addr == ADDR_CTRL_ZERO && i_wdata[3] |-> ##2 !o_ext_pin_enable)
    else $error("high channel code connected a pin");
  chk_read_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_unmapped_zero: assert property (i_rd && i_addr > ADDR_STATUS |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_sample_then_conv: assert property ($fell(o_sample) && o_power_enable |-> o_convert)
    else $error("sampling not followed by conversion");
  chk_irq_at_end: assert property (conv_end |-> ##[0:1] o_irq_request)
    else $error("completion flag not set");
  // the sticky flag output trails the pulse by one cycle
  chk_irq_pulse_cause: assert property (o_irq_pulse |-> $past(i_irq_enable) ##1 (o_irq_request && !o_irq_pulse))
    else $error("interrupt pulse without cause");
  chk_unpowered_idle: assert property (!o_power_enable |=> !o_sample && !o_convert)
    else $error("converter runs while off");
endmodule
bind adc_control_sequencer adc_control_sequencer_monitor mon_u (.i_clock(i_clock), .i_resetn(i_resetn),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_irq_enable(i_irq_enable),
  .o_power_enable(o_power_enable), .o_sample(o_sample), .o_convert(o_convert), .o_ext_pin_enable(o_ext_pin_enable),
  .o_route(o_route), .o_ref_internal(o_ref_internal), .o_irq_request(o_irq_request), .o_irq_pulse(o_irq_pulse));
`default_nettype wire

// ### testbench/adc_control_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_control_sequencer_bench;
  import adc_ctrl_pkg::*;
  logic        i_clock, i_resetn, i_wr, i_rd, i_irq_enable;
  logic [2:0]  i_addr, o_ext_pin_index;
  logic [7:0]  i_wdata, o_rdata, rv, hi, lo;
  logic [11:0] i_conv_result;
  logic        o_power_enable, o_sample, o_convert, o_tick, o_ext_pin_enable, o_ref_internal, o_irq_request, o_irq_pulse;
  route_t      o_route;
  int          n_errors, check_count, n_samp, n_conv, n_pulse, n_tick, n_ctick;
  // rows: ctrl0, ctrl1, expected {route, ref internal, pin enable, pin index}
  logic [7:0]  c0 [8] = '{8'h00, 8'h08, 8'h0F, 8'h09, 8'h0C, 8'h03, 8'h07, 8'h04};
  logic [7:0]  c1 [8] = '{8'h00, 8'h28, 8'h50, 8'h78, 8'h88, 8'hA0, 8'hC8, 8'hE0};
  logic [7:0]  ex [8] = '{8'h08, 8'h30, 8'h47, 8'h61, 8'h94, 8'h0B, 8'h1F, 8'h04};

  adc_control_sequencer dut_u (.i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_irq_enable(i_irq_enable), .i_conv_result(i_conv_result),
    .o_power_enable(o_power_enable), .o_sample(o_sample), .o_convert(o_convert), .o_conv_clock_tick(o_tick),
    .o_ext_pin_enable(o_ext_pin_enable), .o_ext_pin_index(o_ext_pin_index), .o_route(o_route),
    .o_ref_internal(o_ref_internal), .o_irq_request(o_irq_request), .o_irq_pulse(o_irq_pulse));

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    n_samp += int'(o_sample);
    n_conv += int'(o_convert);
    n_pulse += int'(o_irq_pulse);
    n_tick += int'(o_tick);
    n_ctick += int'(o_tick && (o_sample || o_convert));
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic conv(input logic [2:0] dv, input logic j, input logic ie, input logic [11:0] r);
    i_irq_enable <= ie;
    i_conv_result <= r;
    wr(ADDR_CTRL_ONE, {5'h00, dv});
    wr(ADDR_CTRL_ZERO, {3'h1, j, 4'h8});
    repeat (20) @(posedge i_clock);
    wr(ADDR_CTRL_ZERO, {3'h5, j, 4'h8});
    #1 n_samp = 0;
    n_conv = 0;
    n_pulse = 0;
    n_ctick = 0;
    wr(ADDR_CTRL_ZERO, {3'h1, j, 4'h8});
    repeat (3) @(posedge i_clock);
    rd(ADDR_CTRL_ZERO, rv);
    chk("busy", rv, {3'h3, j, 4'h8});
    repeat (40 << dv) @(posedge i_clock);
    chk("sample", 16'(n_samp), 16'(4 << dv));
    chk("convert", 16'(n_conv), 16'(12 << dv));
    chk("conv ticks", 16'(n_ctick), 16'(TOTAL_TICKS));
    chk("pulse", 16'(n_pulse), {15'h0000, ie});
    rd(ADDR_CTRL_ZERO, rv);
    chk("idle", rv, {3'h1, j, 4'h8});
    hi = j ? {4'h0, r[11:8]} : r[11:4];
    lo = j ? r[7:0] : {r[3:0], 4'h0};
    rd(ADDR_RESULT_HIGH, rv);
    chk("high", rv, hi);
    rd(ADDR_RESULT_LOW, rv);
    chk("low", rv, lo);
    rd(ADDR_STATUS, rv);
    chk("flag", rv, 8'h01);
    rd(ADDR_STATUS, rv);
    chk("flag clear", rv, 8'h00);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clock);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    {i_resetn, i_wr, i_rd, i_irq_enable, i_addr, i_wdata, i_conv_result} = '0;
    repeat (8) @(posedge i_clock);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clock);
    rd(ADDR_CTRL_ZERO, rv);
    chk("ctrl0 reset", rv, CTRL_ZERO_RESET);
    rd(ADDR_CTRL_ONE, rv);
    chk("ctrl1 reset", rv, CTRL_ONE_RESET);
    chk("route reset", {5'h00, o_route}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CTRL_ZERO, c0[i]);
      wr(ADDR_CTRL_ONE, c1[i]);
      repeat (2) @(posedge i_clock);
      #1 chk("select", {o_route, o_ref_internal, o_ext_pin_enable, o_ext_pin_index}, ex[i]);
      rd(ADDR_CTRL_ZERO, rv);
      chk("ctrl0", rv, c0[i]);
      rd(ADDR_CTRL_ONE, rv);
      chk("ctrl1", rv, c1[i]);
    end
    rd(3'h5, rv);
    chk("unmapped", rv, 8'h00);
    rd(3'h7, rv);
    chk("unmapped", rv, 8'h00);
    // any 256-cycle window holds exactly 256 / 2**code ticks, whatever the phase
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_CTRL_ONE, 8'(k));
      wr(ADDR_CTRL_ZERO, 8'h28);
      repeat (3) @(posedge i_clock);
      #1 n_tick = 0;
      repeat (256) @(posedge i_clock);
      #1 chk("tick rate", 16'(n_tick), 16'(256 >> k));
      wr(ADDR_CTRL_ZERO, 8'h08);
    end
    // at 50 MHz only codes 5 to 7 keep the converter clock in its accurate range
    conv(3'h5, 1'b0, 1'b1, 12'hA5C);
    conv(3'h6, 1'b1, 1'b0, 12'h3E7);
    conv(3'h7, 1'b0, 1'b1, 12'h81F);
    // a start while off must be ignored; the busy bit cannot be written
    #1 n_samp = 0;
    wr(ADDR_CTRL_ZERO, 8'hC8);
    wr(ADDR_CTRL_ZERO, 8'h48);
    repeat (20) @(posedge i_clock);
    chk("off start", 8'(n_samp), 8'h00);
    rd(ADDR_CTRL_ZERO, rv);
    chk("busy write", rv, 8'h08);
    // power drop mid conversion keeps the old result
    i_conv_result <= 12'h000;
    wr(ADDR_CTRL_ZERO, 8'h28);
    repeat (20) @(posedge i_clock);
    wr(ADDR_CTRL_ZERO, 8'hA8);
    #1 n_pulse = 0;
    wr(ADDR_CTRL_ZERO, 8'h28);
    // with divide by 128 this lands inside the conversion phase
    repeat (800) @(posedge i_clock);
    wr(ADDR_CTRL_ZERO, 8'h08);
    repeat (200) @(posedge i_clock);
    chk("abort pulse", 8'(n_pulse), 8'h00);
    chk("power", {7'h00, o_power_enable}, 8'h00);
    rd(ADDR_RESULT_HIGH, rv);
    chk("kept high", rv, 8'h81);
    rd(ADDR_RESULT_LOW, rv);
    chk("kept low", rv, 8'hF0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
